// *** core/dtc_cfg.svh ***
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// special-function register addresses
`define DTC_ADDR_RUN_FLAG 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_LOW_A 8'h8a
`define DTC_ADDR_LOW_B 8'h8b
`define DTC_ADDR_HIGH_A 8'h8c
`define DTC_ADDR_HIGH_B 8'h8d

// reset values
`define DTC_MODE_RESET 8'h00
`define DTC_RUN_FLAG_RESET 8'h00
`define DTC_COUNT_RESET 8'h00
`define DTC_RDATA_IDLE 8'h00

// timer_mode_config fields
`define DTC_GATE_B 7
`define DTC_SRC_B 6
`define DTC_MODE_B_HI 5
`define DTC_MODE_B_LO 4
`define DTC_GATE_A 3
`define DTC_SRC_A 2
`define DTC_MODE_A_HI 1
`define DTC_MODE_A_LO 0

// timer_run_flag_reg fields
`define DTC_FLAG_B 7
`define DTC_RUN_B 6
`define DTC_FLAG_A 5
`define DTC_RUN_A 4

// pin synchroniser lanes
`define DTC_PIN_COUNT 4
`define DTC_LANE_COUNT_A 0
`define DTC_LANE_COUNT_B 1
`define DTC_LANE_GATE_A 2
`define DTC_LANE_GATE_B 3

`endif

// *** core/dtc_count_unit.sv ***
`timescale 1ns/1ps
`include "dtc_cfg.svh"

module dtc_count_unit #(
    parameter bit SPLIT_OK = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire dtc_pkg::dtc_mode_t i_mode,
    input wire logic i_tick,
    input wire logic i_high_tick,
    input wire logic i_wr_low,
    input wire logic i_wr_high,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_low,
    output logic [7:0] o_high,
    output logic o_ovf,
    output logic o_high_ovf
);
    import dtc_pkg::*;

    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] next_low;
    logic [7:0] next_high;

    // per-mode increment; a core write to a byte beats counting that cycle
    always_comb begin
        next_low = count_low_byte;
        next_high = count_high_byte;
        o_ovf = 1'b0;
        o_high_ovf = 1'b0;
        unique case (i_mode)
            DTC_MODE_PRESCALE: begin
                if (i_tick) begin
                    // low five bits prescale the high byte, upper three hold
                    next_low = {count_low_byte[7:5], count_low_byte[4:0] + 5'h01};
                    if (count_low_byte[4:0] == 5'h1f) begin
                        next_high = count_high_byte + 8'h01;
                        o_ovf = (count_high_byte == 8'hff);
                    end
                end
            end
            DTC_MODE_CASCADE: begin
                if (i_tick) begin
                    {next_high, next_low} = {count_high_byte, count_low_byte} + 16'h0001;
                    o_ovf = ({count_high_byte, count_low_byte} == 16'hffff);
                end
            end
            DTC_MODE_RELOAD: begin
                if (i_tick) begin
                    if (count_low_byte == 8'hff) begin
                        next_low = count_high_byte;
                        o_ovf = 1'b1;
                    end else begin
                        next_low = count_low_byte + 8'h01;
                    end
                end
            end
            DTC_MODE_SPLIT: begin
                // only the first timer splits; the second one simply stops
                if (SPLIT_OK) begin
                    if (i_tick) begin
                        next_low = count_low_byte + 8'h01;
                        o_ovf = (count_low_byte == 8'hff);
                    end
                    if (i_high_tick) begin
                        next_high = count_high_byte + 8'h01;
                        o_high_ovf = (count_high_byte == 8'hff);
                    end
                end
            end
        endcase
        if (i_wr_low) begin
            next_low = i_wdata;
        end
        if (i_wr_high) begin
            next_high = i_wdata;
        end
    end

    // the two bytes of the count, each written separately by the core
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_low_byte <= `DTC_COUNT_RESET;
            count_high_byte <= `DTC_COUNT_RESET;
        end else begin
            count_low_byte <= next_low;
            count_high_byte <= next_high;
        end
    end

    assign o_low = count_low_byte;
    assign o_high = count_high_byte;
endmodule

// *** core/dtc_pin_sync.sv ***
`timescale 1ns/1ps

module dtc_pin_sync (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_pin,
    output logic o_level,
    output logic o_fall
);
    logic meta;
    logic level;
    logic prev;

    // two-flop synchroniser, then one more stage to hold the previous sample
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta <= 1'b0;
            level <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= i_pin;
            level <= meta;
            prev <= level;
        end
    end

    // high in one sample, low in the next; needs two cycles so rate is clk/2
    assign o_level = level;
    assign o_fall = prev & ~level;
endmodule

// *** core/dtc_pkg.sv ***
package dtc_pkg;

    // counting_mode_field encodings
    typedef enum logic [1:0] {
        DTC_MODE_PRESCALE = 2'b00,
        DTC_MODE_CASCADE = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT = 2'b11
    } dtc_mode_t;

endpackage

// *** core/dtc_top.sv ***
// Function
// - two 16-bit timers as high/low bytes
// - timer source counts every core clock
// - counter source counts count-pin falling samples
// - edge detection takes two cycles, half rate
// - mode register at 0x89, zero reset, byte-only
// - bit 7 gates timer B with pin
// - bit 6 selects timer B source
// - mode 00: 5-bit prescaler feeds high byte
// - mode 01: 16-bit cascade, no prescaler
// - mode 10: low byte reloads from high
// - timer B mode 11 halts it
// - bit 3 gates timer A with pin
// - bit 2 selects timer A source
// - timer A modes 00-10 match timer B
// - timer A mode 11 splits bytes
// - overflow sets flag, vector ack clears
`timescale 1ns/1ps
`include "dtc_cfg.svh"

module dtc_top (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic I_SFR_WR,
    input wire logic [7:0] I_SFR_WDATA,
    input wire logic I_VECTOR_ACK_A,
    input wire logic I_VECTOR_ACK_B,
    input wire logic I_COUNT_PIN_A,
    input wire logic I_COUNT_PIN_B,
    input wire logic I_GATE_PIN_A,
    input wire logic I_GATE_PIN_B,
    output logic [7:0] O_SFR_RDATA,
    output logic O_OVERFLOW_FLAG_A,
    output logic O_OVERFLOW_FLAG_B
);
    import dtc_pkg::*;

    // software-visible control state
    logic [7:0] timer_mode_config;
    logic [3:0] run_flag_spare;
    logic run_bit_timer_a;
    logic run_bit_timer_b;

    // synchronised pin lanes
    logic [`DTC_PIN_COUNT-1:0] pin_raw;
    logic [`DTC_PIN_COUNT-1:0] pin_level;
    logic [`DTC_PIN_COUNT-1:0] pin_fall;

    // count enables and timer datapath
    logic tick_a;
    logic tick_b;
    logic split_high_tick;
    logic [7:0] low_a;
    logic [7:0] high_a;
    logic [7:0] low_b;
    logic [7:0] high_b;
    logic ovf_a;
    logic ovf_b;
    logic split_ovf;
    logic unused_ovf_b_high;
    logic set_flag_a;
    logic set_flag_b;
    logic split_active;

    // decoded mode fields and write strobes
    dtc_mode_t mode_a;
    dtc_mode_t mode_b;
    logic wr_mode;
    logic wr_run_flag;
    logic wr_low_a;
    logic wr_low_b;
    logic wr_high_a;
    logic wr_high_b;
    logic [7:0] next_rdata;

    // count enable: run bit, optional gate pin, then clock or pin-edge source;
    // the gate is always the synchronised level, never the raw pin
    function automatic logic dtc_tick(input logic run, input logic gate, input logic gate_level,
                                      input logic src_pin, input logic fall);
        logic enabled;
        enabled = run & (~gate | gate_level);
        dtc_tick = enabled & (src_pin ? fall : 1'b1);
    endfunction

    // write-strobe decode shared by all six byte registers; exact match only
    function automatic logic sfr_write_hit(input logic wr, input logic [7:0] addr,
                                           input logic [7:0] target);
        sfr_write_hit = wr & (addr == target);
    endfunction

    // strobe decode; the mode register has no single-bit access path, so a
    // bit change has to be a read, a modify and a full byte write
    assign wr_mode = sfr_write_hit(I_SFR_WR, I_SFR_ADDR, `DTC_ADDR_MODE);
    assign wr_run_flag = sfr_write_hit(I_SFR_WR, I_SFR_ADDR, `DTC_ADDR_RUN_FLAG);
    assign wr_low_a = sfr_write_hit(I_SFR_WR, I_SFR_ADDR, `DTC_ADDR_LOW_A);
    assign wr_low_b = sfr_write_hit(I_SFR_WR, I_SFR_ADDR, `DTC_ADDR_LOW_B);
    assign wr_high_a = sfr_write_hit(I_SFR_WR, I_SFR_ADDR, `DTC_ADDR_HIGH_A);
    assign wr_high_b = sfr_write_hit(I_SFR_WR, I_SFR_ADDR, `DTC_ADDR_HIGH_B);

    // mode fields of the two timers
    assign mode_a = dtc_mode_t'(timer_mode_config[`DTC_MODE_A_HI:`DTC_MODE_A_LO]);
    assign mode_b = dtc_mode_t'(timer_mode_config[`DTC_MODE_B_HI:`DTC_MODE_B_LO]);

    // split mode of timer A hands its high byte to timer B's controls
    assign split_active = (mode_a == DTC_MODE_SPLIT);

    // all four pins come from outside the clock domain and each passes two
    // flops before any logic reads it
    assign pin_raw[`DTC_LANE_COUNT_A] = I_COUNT_PIN_A;
    assign pin_raw[`DTC_LANE_COUNT_B] = I_COUNT_PIN_B;
    assign pin_raw[`DTC_LANE_GATE_A] = I_GATE_PIN_A;
    assign pin_raw[`DTC_LANE_GATE_B] = I_GATE_PIN_B;

    // pins narrower than one clock may be missed: source must hold each level
    // for a full cycle, so no glitch filtering is added here
    generate
        for (genvar lane = 0; lane < `DTC_PIN_COUNT; lane++) begin : g_pin
            dtc_pin_sync u_sync (
                .i_clk(I_CLK),
                .i_rst_b(I_RST_B),
                .i_pin(pin_raw[lane]),
                .o_level(pin_level[lane]),
                .o_fall(pin_fall[lane])
            );
        end
    endgenerate

    // a pin fall reaches the count about three edges after the pin drops
    // (two sync flops plus the compare stage)
    // timer A tick: gate bit 3, source bit 2
    assign tick_a = dtc_tick(run_bit_timer_a, timer_mode_config[`DTC_GATE_A],
                             pin_level[`DTC_LANE_GATE_A],
                             timer_mode_config[`DTC_SRC_A],
                             pin_fall[`DTC_LANE_COUNT_A]);

    // timer B tick: gate bit 7, source bit 6
    assign tick_b = dtc_tick(run_bit_timer_b, timer_mode_config[`DTC_GATE_B],
                             pin_level[`DTC_LANE_GATE_B],
                             timer_mode_config[`DTC_SRC_B],
                             pin_fall[`DTC_LANE_COUNT_B]);

    // split high byte is a plain clock timer run by timer B's run bit alone
    assign split_high_tick = run_bit_timer_b;

    // timer A is the only unit allowed to split its two bytes
    dtc_count_unit #(
        .SPLIT_OK(1'b1)
    ) u_timer_a (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_mode(mode_a),
        .i_tick(tick_a),
        .i_high_tick(split_high_tick),
        .i_wr_low(wr_low_a),
        .i_wr_high(wr_high_a),
        .i_wdata(I_SFR_WDATA),
        .o_low(low_a),
        .o_high(high_a),
        .o_ovf(ovf_a),
        .o_high_ovf(split_ovf)
    );

    // mode 11 of the second timer halts both bytes inside the unit
    dtc_count_unit #(
        .SPLIT_OK(1'b0)
    ) u_timer_b (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_mode(mode_b),
        .i_tick(tick_b),
        .i_high_tick(1'b0),
        .i_wr_low(wr_low_b),
        .i_wr_high(wr_high_b),
        .i_wdata(I_SFR_WDATA),
        .o_low(low_b),
        .o_high(high_b),
        .o_ovf(ovf_b),
        .o_high_ovf(unused_ovf_b_high)
    );

    // while timer A is split its high byte owns timer B's flag; timer B keeps
    // counting but can no longer raise a flag of its own
    assign set_flag_a = ovf_a;
    assign set_flag_b = split_active ? split_ovf : ovf_b;
    // timer B's high-byte overflow stays unused: its mode 11 is a halt

    // mode register, byte writes only
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            timer_mode_config <= `DTC_MODE_RESET;
        end else if (wr_mode) begin
            timer_mode_config <= I_SFR_WDATA;
        end
    end

    // run bit of timer A; only a full byte write to the run/flag register moves it
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            run_bit_timer_a <= 1'b0;
        end else if (wr_run_flag) begin
            run_bit_timer_a <= I_SFR_WDATA[`DTC_RUN_A];
        end
    end

    // run bit of timer B; it also runs timer A's high byte while A is split
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            run_bit_timer_b <= 1'b0;
        end else if (wr_run_flag) begin
            run_bit_timer_b <= I_SFR_WDATA[`DTC_RUN_B];
        end
    end

    // spare low nibble is plain storage, so a read-modify-write returns it intact
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            run_flag_spare <= 4'h0;
        end else if (wr_run_flag) begin
            run_flag_spare <= I_SFR_WDATA[3:0];
        end
    end

    // overflow flag A: a hardware set in the same cycle as a vector clear or a
    // core write wins, so no overflow is ever lost
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_OVERFLOW_FLAG_A <= 1'b0;
        end else begin
            if (set_flag_a) begin
                O_OVERFLOW_FLAG_A <= 1'b1;
            end else if (I_VECTOR_ACK_A) begin
                O_OVERFLOW_FLAG_A <= 1'b0;
            end else if (wr_run_flag) begin
                O_OVERFLOW_FLAG_A <= I_SFR_WDATA[`DTC_FLAG_A];
            end
        end
    end

    // overflow flag B: same priority; while A is split it follows A's high byte
    // and timer B's own rollovers are dropped
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_OVERFLOW_FLAG_B <= 1'b0;
        end else begin
            if (set_flag_b) begin
                O_OVERFLOW_FLAG_B <= 1'b1;
            end else if (I_VECTOR_ACK_B) begin
                O_OVERFLOW_FLAG_B <= 1'b0;
            end else if (wr_run_flag) begin
                O_OVERFLOW_FLAG_B <= I_SFR_WDATA[`DTC_FLAG_B];
            end
        end
    end

    // read mux; unmapped addresses read zero so the core's own mux can OR us in
    // the two bytes of a count are read separately and not latched together, so
    // software must allow for a roll between the two reads
    always_comb begin
        unique case (I_SFR_ADDR)
            `DTC_ADDR_MODE: begin
                next_rdata = timer_mode_config;
            end
            `DTC_ADDR_RUN_FLAG: begin
                next_rdata = {O_OVERFLOW_FLAG_B, run_bit_timer_b,
                              O_OVERFLOW_FLAG_A, run_bit_timer_a,
                              run_flag_spare};
            end
            `DTC_ADDR_LOW_A: begin
                next_rdata = low_a;
            end
            `DTC_ADDR_LOW_B: begin
                next_rdata = low_b;
            end
            `DTC_ADDR_HIGH_A: begin
                next_rdata = high_a;
            end
            `DTC_ADDR_HIGH_B: begin
                next_rdata = high_b;
            end
            default: begin
                next_rdata = `DTC_RDATA_IDLE;
            end
        endcase
    end

    // registered read data costs one cycle of latency but keeps the output clean
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_SFR_RDATA <= `DTC_RDATA_IDLE;
        end else begin
            O_SFR_RDATA <= next_rdata;
        end
    end
endmodule

// *** dv/dtc_core_model.sv ***
`timescale 1ns/1ps
module dtc_core_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic [7:0] o_wdata,
    output logic o_ack_a,
    output logic o_ack_b
);
    initial {o_addr, o_wr, o_wdata, o_ack_a, o_ack_b} = 19'h00000;
    // one-cycle strobe; data is inverted once released so nothing leans on it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wr <= 1'b1;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    // read data is registered, so it is taken one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        @(posedge i_clk);
        #1 d = i_rdata;
    endtask
    // vector taken: one-cycle acknowledge to the chosen timer
    task automatic ack(input bit b);
        @(posedge i_clk);
        {o_ack_b, o_ack_a} <= b ? 2'h2 : 2'h1;
        @(posedge i_clk);
        {o_ack_b, o_ack_a} <= 2'h0;
    endtask
endmodule

// *** dv/dtc_top_assertions.sv ***
`timescale 1ns/1ps
module dtc_top_chk (
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic I_SFR_WR,
    input wire logic [7:0] I_SFR_WDATA,
    input wire logic I_VECTOR_ACK_A,
    input wire logic I_GATE_PIN_A,
    input wire logic I_GATE_PIN_B,
    input wire logic [7:0] O_SFR_RDATA,
    input wire logic O_OVERFLOW_FLAG_A
);
    logic [7:0] mode;
    logic [7:0] run;
    logic [1:0] lo_a;
    logic [1:0] lo_b;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);
    // shadow of software controls; hardware never alters mode or run bits
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            mode <= 8'h00;
            run <= 8'h00;
        end else if (I_SFR_WR && I_SFR_ADDR == 8'h89) begin
            mode <= I_SFR_WDATA;
        end else if (I_SFR_WR && I_SFR_ADDR == 8'h88) begin
            run <= I_SFR_WDATA;
        end
    end
    // gate pins pass two sync flops, so three low samples mean the gate is shut
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            lo_a <= 2'h0;
            lo_b <= 2'h0;
        end else begin
            lo_a <= I_GATE_PIN_A ? 2'h0 : (lo_a == 2'h3 ? 2'h3 : lo_a + 2'h1);
            lo_b <= I_GATE_PIN_B ? 2'h0 : (lo_b == 2'h3 ? 2'h3 : lo_b + 2'h1);
        end
    end
    // read path, flag retention and per-timer counting behaviour
    a_mode_readback:
    assert property (I_SFR_WR && I_SFR_ADDR == 8'h89 ##1 I_SFR_ADDR == 8'h89
        |=> O_SFR_RDATA == $past(I_SFR_WDATA, 2)) else $error("mode readback");
    a_unmapped_zero:
    assert property (!(I_SFR_ADDR inside {[8'h88:8'h8d]}) |=> O_SFR_RDATA == 8'h00)
        else $error("unmapped read");
    a_flag_a_hold:
    assert property (O_OVERFLOW_FLAG_A && !I_VECTOR_ACK_A
        && !(I_SFR_WR && I_SFR_ADDR == 8'h88) |=> O_OVERFLOW_FLAG_A) else $error("flag lost");
    a_count_a_step:
    assert property ((mode[0] && mode[3:2] == 2'h0 && run[4] && I_SFR_ADDR == 8'h8a
        && !I_SFR_WR) [*2] |=> O_SFR_RDATA == 8'($past(O_SFR_RDATA) + 8'h01))
        else $error("timer step");
    a_halt_b_frozen:
    assert property ((mode[5:4] == 2'h3 && I_SFR_ADDR == 8'h8b && !I_SFR_WR) [*2]
        |=> $stable(O_SFR_RDATA)) else $error("halted timer moved");
    a_gate_a_hold:
    assert property (((!run[4] || (mode[3] && lo_a == 2'h3)) && I_SFR_ADDR == 8'h8a
        && !I_SFR_WR) [*2] |=> $stable(O_SFR_RDATA)) else $error("gated timer moved");
    a_gate_b_hold:
    assert property (((!run[6] || (mode[7] && lo_b == 2'h3)) && I_SFR_ADDR == 8'h8b
        && !I_SFR_WR) [*2] |=> $stable(O_SFR_RDATA)) else $error("gated timer moved");
    a_unmapped_quiet:
    assert property (I_SFR_ADDR == 8'h8e ##1 I_SFR_ADDR == 8'h87 |=> O_SFR_RDATA == 8'h00)
        else $error("hole read");
endmodule
bind dtc_top dtc_top_chk u_chk (.I_CLK, .I_RST_B, .I_SFR_ADDR, .I_SFR_WR, .I_SFR_WDATA,
    .I_VECTOR_ACK_A, .I_GATE_PIN_A, .I_GATE_PIN_B, .O_SFR_RDATA, .O_OVERFLOW_FLAG_A);

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_b;
    logic [7:0] addr, wdata, rdata, d, x;
    logic wr, ack_a, ack_b, flag_a, flag_b;
    logic [1:0] cnt, gt;
    logic noise = 1'b0;
    logic [16:0] e;
    integer seed = 36;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    dtc_top uut (.I_CLK(clk), .I_RST_B(rst_b), .I_SFR_ADDR(addr), .I_SFR_WR(wr),
        .I_SFR_WDATA(wdata), .I_VECTOR_ACK_A(ack_a), .I_VECTOR_ACK_B(ack_b),
        .I_COUNT_PIN_A(cnt[0]), .I_COUNT_PIN_B(cnt[1]), .I_GATE_PIN_A(gt[0]),
        .I_GATE_PIN_B(gt[1]), .O_SFR_RDATA(rdata), .O_OVERFLOW_FLAG_A(flag_a),
        .O_OVERFLOW_FLAG_B(flag_b));
    dtc_core_model core (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
        .o_wdata(wdata), .o_ack_a(ack_a), .o_ack_b(ack_b));
    // pins are noise during the count runs; run is cut short far beyond the expected length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (noise) begin
            cnt <= 2'($random(seed));
            gt <= 2'($random(seed));
        end
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [16:0] s, input logic [16:0] ex);
        n_checks++;
        if (s !== ex) begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, ex, s);
        end
    endtask
    // expected {flag, high, low} after n ticks; a selects timer A split behaviour
    function automatic logic [16:0] calc(input bit a, input logic [1:0] m,
        input logic [7:0] h, input logic [7:0] l, input int n);
        logic f;
        f = 1'b0;
        for (int i = 0; i < n; i++) begin
            case (m)
                2'h0: begin
                    l[4:0] = l[4:0] + 5'h01;
                    h = (l[4:0] == 5'h00) ? h + 8'h01 : h;
                    f = f | (l[4:0] == 5'h00 && h == 8'h00);
                end
                2'h1: begin
                    {h, l} = {h, l} + 16'h0001;
                    f = f | ({h, l} == 16'h0000);
                end
                2'h2: begin
                    f = f | (l == 8'hff);
                    l = (l == 8'hff) ? h : l + 8'h01;
                end
                default: begin
                    l = a ? l + 8'h01 : l;
                    f = f | (a && l == 8'h00);
                end
            endcase
        end
        return {f, h, l};
    endfunction
    // load, run a random span, read back; corner runs start just below rollover
    task automatic run_t(input bit b, input logic [1:0] m, input bit c);
        logic [7:0] h, l, lo;
        bit ak;
        int k;
        h = c ? 8'hff : 8'($random(seed));
        l = c ? 8'hfe : 8'($random(seed));
        lo = b ? 8'h8b : 8'h8a;
        k = 1 + ($random(seed) & 15);
        noise = 1'b1;
        core.wr(8'h89, b ? {2'h0, m, 4'h0} : {6'h00, m});
        core.wr(lo, l);
        core.wr(lo + 8'h02, h);
        core.wr(8'h88, b ? 8'h40 : 8'h10);
        repeat (k) core.rd(lo, d);
        e = calc(!b, m, h, l, 2 * k);
        chk("flag", {16'h0000, b ? flag_b : flag_a}, {16'h0000, e[16]});
        ak = m == 2'h1 && e[16];
        if (ak) begin
            core.ack(b);
            #1 chk("flag after ack", {16'h0000, b ? flag_b : flag_a}, 17'h00000);
        end
        // second stop write clears a flag that a same-edge overflow set again
        core.wr(8'h88, 8'h00);
        core.wr(8'h88, 8'h00);
        noise = 1'b0;
        e = calc(!b, m, h, l, 2 * k + (ak ? 4 : 2));
        core.rd(lo, d);
        chk("low", {9'h000, d}, {9'h000, e[7:0]});
        core.rd(lo + 8'h02, d);
        chk("high", {9'h000, d}, {9'h000, e[15:8]});
        $display("count test timer %0d mode %0d done", b, m);
    endtask
    // count-pin edges at the fastest legal rate, then the gate pin shuts the timer
    task automatic pin_t(input bit b);
        logic [7:0] l, lo, d0;
        int p;
        l = 8'($random(seed));
        lo = b ? 8'h8b : 8'h8a;
        p = 1 + ($random(seed) & 31);
        @(posedge clk);
        cnt[b] <= 1'b0;
        gt[b] <= 1'b0;
        core.wr(8'h89, b ? 8'h50 : 8'h05);
        core.wr(lo, l);
        core.wr(8'h88, b ? 8'h40 : 8'h10);
        repeat (p) begin
            @(posedge clk);
            cnt[b] <= 1'b1;
            @(posedge clk);
            cnt[b] <= 1'b0;
        end
        repeat (6) @(posedge clk);
        core.rd(lo, d);
        chk("pin count", {9'h000, d}, {9'h000, 8'(l + p)});
        core.wr(8'h89, b ? 8'h90 : 8'h09);
        core.rd(lo, d0);
        repeat (4) core.rd(lo, d);
        chk("gated", {9'h000, d}, {9'h000, d0});
        $display("pin test timer %0d done", b);
    endtask
    initial begin
        rst_b = 1'b0;
        cnt = 2'h0;
        gt = 2'h0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        // mapped bytes reset to zero, the unmapped neighbours read zero
        for (int i = 8'h8e; i >= 8'h87; i--) begin
            core.rd(8'(i), d);
            chk("reset value", {9'h000, d}, 17'h00000);
        end
        // two holes back to back, so the read path must follow each new address
        core.rd(8'h8e, d);
        core.rd(8'h87, d);
        chk("hole read", {9'h000, d}, 17'h00000);
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            x = 8'($random(seed));
            core.wr(8'h89, x);
            core.rd(8'h89, d);
            chk("mode", {9'h000, d}, {9'h000, x});
        end
        $display("mode test done");
        for (int r = 0; r < 16; r++) begin
            run_t(r[0], r[2:1], r[3]);
        end
        pin_t(1'b0);
        pin_t(1'b1);
        give_verdict();
    end
endmodule
